// ---- include/light_sensor_pkg.sv ----
package light_sensor_pkg;

    // ====================================================
    // widths
    localparam int DATA_W         = 20;
    localparam int ADDR_W         = 8;
    localparam int SAMPLE_W       = 8;
    localparam int PERSIST_W      = 4;
    localparam int VAR_W          = 3;
    localparam int CYC_W          = 16;
    localparam int INT_CYCLES_DEF = 64;

    // ====================================================
    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_IRQ_CFG = 8'h04;
    localparam logic [7:0] OFS_PERSIST = 8'h08;
    localparam logic [7:0] OFS_THR_HI  = 8'h0C;
    localparam logic [7:0] OFS_THR_LO  = 8'h10;
    localparam logic [7:0] OFS_VAR     = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;
    localparam logic [7:0] OFS_RED     = 8'h20;
    localparam logic [7:0] OFS_GREEN   = 8'h24;
    localparam logic [7:0] OFS_BLUE    = 8'h28;
    localparam logic [7:0] OFS_IR      = 8'h2C;

    // ====================================================
    // field positions
    localparam int CTRL_MEAS_BIT = 0;
    localparam int CFG_EN_BIT    = 0;
    localparam int CFG_VAR_BIT   = 1;
    localparam int CFG_SEL_LSB   = 2;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_NEW_BIT  = 1;
    localparam int STAT_PIN_BIT  = 2;

    // ====================================================
    // channel codes and reset values
    localparam logic [1:0]           CH_RED      = 2'h0;
    localparam logic [1:0]           CH_GREEN    = 2'h1;
    localparam logic [1:0]           CH_BLUE     = 2'h2;
    localparam logic [1:0]           CH_IR       = 2'h3;
    localparam logic [DATA_W-1:0]    THR_HI_RST  = 20'hFFFFF;
    localparam logic [DATA_W-1:0]    THR_LO_RST  = 20'h00000;
    localparam logic [PERSIST_W-1:0] PERSIST_RST = 4'h1;
    localparam logic [VAR_W-1:0]     VAR_RST     = 3'h0;
    localparam logic [DATA_W-1:0]    VAR_BASE    = 20'h00008;

    typedef enum logic [1:0] {
        CONV_IDLE  = 2'b00,
        CONV_INTEG = 2'b01,
        CONV_DONE  = 2'b10
    } conv_state_t;

endpackage : light_sensor_pkg

// ---- src/conv_capture.sv ----
`timescale 1ns/1ns
module conv_capture #(
    parameter int SAMPLE_W   = light_sensor_pkg::SAMPLE_W,
    parameter int DATA_W     = light_sensor_pkg::DATA_W,
    parameter int INT_CYCLES = light_sensor_pkg::INT_CYCLES_DEF
) (
    input  wire logic                adc_clk_i,
    input  wire logic                adc_rstn_i,
    input  wire logic                mclk_i,
    input  wire logic                rstn_i,
    input  wire logic                meas_enable_i,
    input  wire logic [SAMPLE_W-1:0] red_sample_i,
    input  wire logic [SAMPLE_W-1:0] green_sample_i,
    input  wire logic [SAMPLE_W-1:0] blue_sample_i,
    input  wire logic [SAMPLE_W-1:0] ir_sample_i,
    output logic                     done_o,
    output logic [3:0][DATA_W-1:0]   result_o
);

    // ====================================================
    // link side: concurrent integration of all channels
    typedef struct packed {
        logic [2:0]                          en_sync;
        logic                                en_on;
        light_sensor_pkg::conv_state_t       state;
        logic [light_sensor_pkg::CYC_W-1:0]  cnt;
        logic [3:0][DATA_W-1:0]              acc;
        logic [3:0][DATA_W-1:0]              res;
        logic                                tgl;
    } link_t;

    typedef struct packed {
        logic [2:0] tgl_sync;
        logic       tgl_seen;
        logic       done;
    } main_t;

    link_t                     l_reg, l_next;
    main_t                     m_reg, m_next;
    logic [3:0][SAMPLE_W-1:0]  samples;

    assign samples = {ir_sample_i, blue_sample_i, green_sample_i, red_sample_i};

    function automatic logic [DATA_W-1:0] sat_add(input logic [DATA_W-1:0] a,
                                                  input logic [SAMPLE_W-1:0] b);
        logic [DATA_W:0] s;
        s = {1'b0, a} + {{(DATA_W+1-SAMPLE_W){1'b0}}, b};
        sat_add = s[DATA_W] ? {DATA_W{1'b1}} : s[DATA_W-1:0];
    endfunction : sat_add

    always_comb begin
        l_next = l_reg;
        l_next.en_sync = {l_reg.en_sync[1:0], meas_enable_i};
        if (l_reg.en_sync[1] == l_reg.en_sync[2]) begin
            l_next.en_on = l_reg.en_sync[2];
        end
        case (l_reg.state)
            light_sensor_pkg::CONV_IDLE: begin
                if (l_reg.en_on) begin
                    l_next.acc   = '0;
                    l_next.cnt   = '0;
                    l_next.state = light_sensor_pkg::CONV_INTEG;
                end
            end
            light_sensor_pkg::CONV_INTEG: begin
                for (int c = 0; c < 4; c++) begin
                    l_next.acc[c] = sat_add(l_reg.acc[c], samples[c]); // R01
                end
                if (l_reg.cnt == light_sensor_pkg::CYC_W'(INT_CYCLES - 1)) begin
                    l_next.state = light_sensor_pkg::CONV_DONE;
                end else begin
                    l_next.cnt = l_reg.cnt + 1'b1;
                end
            end
            light_sensor_pkg::CONV_DONE: begin
                l_next.res   = l_reg.acc;
                l_next.tgl   = ~l_reg.tgl;
                l_next.state = light_sensor_pkg::CONV_IDLE;
            end
            default: begin
                l_next.state = light_sensor_pkg::CONV_IDLE;
            end
        endcase
    end

    always_ff @(posedge adc_clk_i) begin
        if (!adc_rstn_i) begin
            l_reg <= '0;
        end else begin
            l_reg <= l_next;
        end
    end

    // ====================================================
    // main side: toggle crossing, results held stable meanwhile
    always_comb begin
        m_next          = m_reg;
        m_next.tgl_sync = {m_reg.tgl_sync[1:0], l_reg.tgl};
        m_next.done     = 1'b0;
        if (m_reg.tgl_sync[1] == m_reg.tgl_sync[2] && m_reg.tgl_sync[2] != m_reg.tgl_seen) begin
            m_next.tgl_seen = m_reg.tgl_sync[2];
            m_next.done     = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            m_reg <= '0;
        end else begin
            m_reg <= m_next;
        end
    end

    assign done_o   = m_reg.done;
    assign result_o = l_reg.res;

endmodule : conv_capture

// ---- src/light_sensor_result_and_irq.sv ----
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
// How it works
// R01: all four channels integrate together in one conversion, not one after another.
// R02: at conversion end every channel result lands in its own readable data register.
// R03: enabled interrupt, once triggered, holds the pin until software clears it.
// R04: interrupt condition is evaluated only when a new conversion completes.
// R05: any one of red, green, blue or infrared may drive the comparison.
// R06: count consecutive exceeding conversions; fire at persistence value; reset on miss.
// R07: host reaches control and results over a two-wire bus up to fast mode; here a strobed parallel register port instead.
// R08: interrupt pin is active-low open drain, released when not asserted.
// R09: enable bit gates interrupt; mode bit picks threshold or variance triggering.
// R10: threshold mode exceeds when result is above upper or below lower limit.
// R11: variance mode exceeds when previous-to-current difference passes decoded threshold.
// R12: interrupt channel comes from a select field in interrupt configuration.
module light_sensor_result_and_irq #(
    parameter int SAMPLE_W   = light_sensor_pkg::SAMPLE_W,
    parameter int DATA_W     = light_sensor_pkg::DATA_W,
    parameter int INT_CYCLES = light_sensor_pkg::INT_CYCLES_DEF
) (
    input  wire logic                                 mclk_i,
    input  wire logic                                 rstn_i,
    input  wire logic                                 adc_clk_i,
    input  wire logic                                 adc_rstn_i,
    input  wire logic [light_sensor_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [31:0]                          wdata_i,
    input  wire logic                                 wr_i,
    input  wire logic                                 rd_i,
    output logic      [31:0]                          rdata_o,
    input  wire logic [SAMPLE_W-1:0]                  red_sample_i,
    input  wire logic [SAMPLE_W-1:0]                  green_sample_i,
    input  wire logic [SAMPLE_W-1:0]                  blue_sample_i,
    input  wire logic [SAMPLE_W-1:0]                  ir_sample_i,
    input  wire logic                                 irq_pin_n_i,
    output logic                                      irq_n_o,
    output logic                                      irq_oe_o
);

    // ====================================================
    // state
    typedef struct packed {
        logic                                     meas_en;
        logic                                     light_irq_enable;
        logic                                     irq_variance_select;
        logic [1:0]                               irq_channel_select;
        logic [light_sensor_pkg::PERSIST_W-1:0]   persist;
        logic [DATA_W-1:0]                        thr_hi;
        logic [DATA_W-1:0]                        thr_lo;
        logic [light_sensor_pkg::VAR_W-1:0]       var_code;
        logic [3:0][DATA_W-1:0]                   data;
        logic                                     pend;
        logic                                     new_data;
        logic [light_sensor_pkg::PERSIST_W-1:0]   exc_cnt;
        logic [2:0]                               pin_sync;
        logic                                     pin_lvl;
        logic [31:0]                              rdata;
    } state_t;

    state_t                       s_reg;
    state_t                       s_next;
    logic                         conv_done;
    logic [3:0][DATA_W-1:0]       result;
    logic [DATA_W-1:0]            cur_val;
    logic [DATA_W-1:0]            prev_val;
    logic                         exceed;
    logic [light_sensor_pkg::PERSIST_W-1:0] cnt_step;

    // ====================================================
    // conversion front end and crossing
    conv_capture #(
        .SAMPLE_W   (SAMPLE_W),
        .DATA_W     (DATA_W),
        .INT_CYCLES (INT_CYCLES)
    ) u_conv (
        .adc_clk_i      (adc_clk_i),
        .adc_rstn_i     (adc_rstn_i),
        .mclk_i         (mclk_i),
        .rstn_i         (rstn_i),
        .meas_enable_i  (s_reg.meas_en),
        .red_sample_i   (red_sample_i),
        .green_sample_i (green_sample_i),
        .blue_sample_i  (blue_sample_i),
        .ir_sample_i    (ir_sample_i),
        .done_o         (conv_done),
        .result_o       (result)
    );

    // ====================================================
    // helpers
    function automatic logic [DATA_W-1:0] abs_diff(input logic [DATA_W-1:0] a,
                                                   input logic [DATA_W-1:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction : abs_diff

    function automatic logic [DATA_W-1:0] var_decode(
        input logic [light_sensor_pkg::VAR_W-1:0] code
    );
        var_decode = light_sensor_pkg::VAR_BASE << code;
    endfunction : var_decode

    function automatic logic [31:0] widen(input logic [DATA_W-1:0] v);
        widen = {{(32-DATA_W){1'b0}}, v};
    endfunction : widen

    // ====================================================
    // interrupt comparison
    always_comb begin
        cur_val  = result[s_reg.irq_channel_select];                 // R05 R12
        prev_val = s_reg.data[s_reg.irq_channel_select];
        if (s_reg.irq_variance_select) begin                         // R09
            exceed = abs_diff(cur_val, prev_val) > var_decode(s_reg.var_code); // R11
        end else begin
            exceed = (cur_val > s_reg.thr_hi) || (cur_val < s_reg.thr_lo); // R10
        end
        if (&s_reg.exc_cnt) begin
            cnt_step = s_reg.exc_cnt;
        end else begin
            cnt_step = s_reg.exc_cnt + 1'b1;
        end
    end

    // ====================================================
    // next state
    always_comb begin
        s_next          = s_reg;
        s_next.rdata    = 32'h00000000;
        s_next.pin_sync = {s_reg.pin_sync[1:0], irq_pin_n_i};
        if (s_reg.pin_sync[1] == s_reg.pin_sync[2]) begin
            s_next.pin_lvl = s_reg.pin_sync[2];
        end

        // register writes, single cycle, no wait states
        if (wr_i) begin                                              // R07
            case (addr_i)
                light_sensor_pkg::OFS_CTRL: begin
                    s_next.meas_en = wdata_i[light_sensor_pkg::CTRL_MEAS_BIT];
                end
                light_sensor_pkg::OFS_IRQ_CFG: begin
                    s_next.light_irq_enable    = wdata_i[light_sensor_pkg::CFG_EN_BIT];
                    s_next.irq_variance_select = wdata_i[light_sensor_pkg::CFG_VAR_BIT];
                    s_next.irq_channel_select  =
                        wdata_i[light_sensor_pkg::CFG_SEL_LSB +: 2];     // R12
                end
                light_sensor_pkg::OFS_PERSIST: begin
                    s_next.persist = wdata_i[light_sensor_pkg::PERSIST_W-1:0];
                end
                light_sensor_pkg::OFS_THR_HI: begin
                    s_next.thr_hi = wdata_i[DATA_W-1:0];
                end
                light_sensor_pkg::OFS_THR_LO: begin
                    s_next.thr_lo = wdata_i[DATA_W-1:0];
                end
                light_sensor_pkg::OFS_VAR: begin
                    s_next.var_code = wdata_i[light_sensor_pkg::VAR_W-1:0];
                end
                light_sensor_pkg::OFS_STATUS: begin
                    if (wdata_i[light_sensor_pkg::STAT_PEND_BIT]) begin
                        s_next.pend = 1'b0;                          // R03
                    end
                end
                default: begin
                end
            endcase
            // counting restarts on any interrupt configuration write, unless a conversion ends in the same cycle
            if (addr_i == light_sensor_pkg::OFS_IRQ_CFG) begin
                s_next.exc_cnt = '0;
            end
        end

        // register reads, data in the following cycle only
        if (rd_i) begin
            case (addr_i)
                light_sensor_pkg::OFS_CTRL: begin
                    s_next.rdata[light_sensor_pkg::CTRL_MEAS_BIT] = s_reg.meas_en;
                end
                light_sensor_pkg::OFS_IRQ_CFG: begin
                    s_next.rdata[light_sensor_pkg::CFG_EN_BIT]  = s_reg.light_irq_enable;
                    s_next.rdata[light_sensor_pkg::CFG_VAR_BIT] = s_reg.irq_variance_select;
                    s_next.rdata[light_sensor_pkg::CFG_SEL_LSB +: 2] =
                        s_reg.irq_channel_select;
                end
                light_sensor_pkg::OFS_PERSIST: begin
                    s_next.rdata[light_sensor_pkg::PERSIST_W-1:0] = s_reg.persist;
                end
                light_sensor_pkg::OFS_THR_HI: begin
                    s_next.rdata = widen(s_reg.thr_hi);
                end
                light_sensor_pkg::OFS_THR_LO: begin
                    s_next.rdata = widen(s_reg.thr_lo);
                end
                light_sensor_pkg::OFS_VAR: begin
                    s_next.rdata[light_sensor_pkg::VAR_W-1:0] = s_reg.var_code;
                end
                light_sensor_pkg::OFS_STATUS: begin
                    s_next.rdata[light_sensor_pkg::STAT_PEND_BIT] = s_reg.pend;
                    s_next.rdata[light_sensor_pkg::STAT_NEW_BIT]  = s_reg.new_data;
                    s_next.rdata[light_sensor_pkg::STAT_PIN_BIT]  = s_reg.pin_lvl;
                    s_next.new_data = 1'b0;
                end
                light_sensor_pkg::OFS_RED: begin
                    s_next.rdata = widen(s_reg.data[light_sensor_pkg::CH_RED]);
                end
                light_sensor_pkg::OFS_GREEN: begin
                    s_next.rdata = widen(s_reg.data[light_sensor_pkg::CH_GREEN]);
                end
                light_sensor_pkg::OFS_BLUE: begin
                    s_next.rdata = widen(s_reg.data[light_sensor_pkg::CH_BLUE]);
                end
                light_sensor_pkg::OFS_IR: begin
                    s_next.rdata = widen(s_reg.data[light_sensor_pkg::CH_IR]);
                end
                default: begin
                    s_next.rdata = 32'h00000000;
                end
            endcase
        end

        // conversion end: results land and the trigger is judged once, in the same cycle
        if (conv_done) begin                                         // R04
            s_next.data     = result;                                // R02
            s_next.new_data = 1'b1;
            if (!s_reg.light_irq_enable) begin
                s_next.exc_cnt = '0;
            end else if (exceed) begin
                s_next.exc_cnt = cnt_step;                           // R06
                if (cnt_step >= s_reg.persist) begin
                    s_next.pend = 1'b1;                              // R03 R09
                end
            end else begin
                s_next.exc_cnt = '0;                                 // R06
            end
        end
    end

    // ====================================================
    // state register
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            s_reg          <= '0;
            s_reg.thr_hi   <= light_sensor_pkg::THR_HI_RST;
            s_reg.thr_lo   <= light_sensor_pkg::THR_LO_RST;
            s_reg.persist  <= light_sensor_pkg::PERSIST_RST;
            s_reg.var_code <= light_sensor_pkg::VAR_RST;
            s_reg.pin_sync <= 3'h7;
            s_reg.pin_lvl  <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ====================================================
    // outputs
    assign rdata_o  = s_reg.rdata;
    assign irq_n_o  = 1'b0;                                          // R08
    assign irq_oe_o = s_reg.pend;                                    // R08 R03

endmodule : light_sensor_result_and_irq

// ---- tb/light_sample_source.sv ----
`timescale 1ns/1ns
module light_sample_source (
    input  wire logic                                      adc_clk_i,
    input  wire logic [3:0][light_sensor_pkg::SAMPLE_W-1:0] level_i,
    input  wire logic                                      irq_oe_i,
    output logic      [3:0][light_sensor_pkg::SAMPLE_W-1:0] sample_o,
    output logic                                           irq_wire_n_o
);
    // all four photodiodes deliver over the same link cycles
    always_ff @(posedge adc_clk_i) begin
        sample_o <= level_i;
    end

    // pull-up on the shared interrupt wire
    assign irq_wire_n_o = irq_oe_i ? 1'b0 : 1'b1;
endmodule : light_sample_source

// ---- tb/light_sensor_result_and_irq_monitor.sv ----
`timescale 1ns/1ns
module light_sensor_result_and_irq_monitor (
    input  wire logic                                mclk_i,
    input  wire logic                                rstn_i,
    input  wire logic [light_sensor_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [31:0]                         wdata_i,
    input  wire logic                                wr_i,
    input  wire logic                                rd_i,
    input  wire logic [31:0]                         rdata_o,
    input  wire logic                                irq_n_o,
    input  wire logic                                irq_oe_o
);
    // ====================================================
    // shadow of interrupt configuration
    logic [3:0] cfg_reg;
    logic       mapped;

    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            cfg_reg <= 4'h0;
        end else if (wr_i && addr_i == light_sensor_pkg::OFS_IRQ_CFG) begin
            cfg_reg <= wdata_i[3:0];
        end
    end

    assign mapped = addr_i inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                                   8'h20, 8'h24, 8'h28, 8'h2C};

    // ====================================================
    // properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_pend_kept;
        irq_oe_o && !(wr_i && addr_i == light_sensor_pkg::OFS_STATUS && wdata_i[0]);
    endsequence

    property p_irq_hold;
        s_pend_kept |=> irq_oe_o;
    endproperty
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 32'h0;
    endproperty
    property p_rd_unmapped;
        $past(rd_i && !mapped) |-> rdata_o == 32'h0;
    endproperty
    property p_data_width;
        $past(rd_i && addr_i >= light_sensor_pkg::OFS_RED) |-> rdata_o[31:20] == 12'h000;
    endproperty
    property p_pend_read;
        $past(rd_i && addr_i == light_sensor_pkg::OFS_STATUS) |-> rdata_o[0] == $past(irq_oe_o);
    endproperty
    property p_irq_gate;
        $rose(irq_oe_o) |-> $past(cfg_reg[0]);
    endproperty
    property p_cfg_read;
        $past(rd_i && addr_i == light_sensor_pkg::OFS_IRQ_CFG) |-> rdata_o[3:0] == $past(cfg_reg);
    endproperty
    property p_od_data;
        irq_n_o == 1'b0;
    endproperty

    a_irq_hold:    assert property (p_irq_hold) else $error("interrupt dropped");
    a_rd_idle:     assert property (p_rd_idle) else $error("read data without read");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not 0");
    a_data_width:  assert property (p_data_width) else $error("data upper bits set");
    a_pend_read:   assert property (p_pend_read) else $error("pending bit mismatch");
    a_irq_gate:    assert property (p_irq_gate) else $error("irq while disabled");
    a_cfg_read:    assert property (p_cfg_read) else $error("config readback wrong");
    a_od_data:     assert property (p_od_data) else $error("pin data not low");
endmodule : light_sensor_result_and_irq_monitor

bind light_sensor_result_and_irq light_sensor_result_and_irq_monitor
    i_light_sensor_result_and_irq_monitor (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_n_o(irq_n_o),
    .irq_oe_o(irq_oe_o));

// ---- tb/test_light_sensor_result_and_irq.sv ----
`timescale 1ns/1ns
module test_light_sensor_result_and_irq;
    localparam int INT_CYC = 4;
    logic            mclk_i = 1'b0;
    logic            adc_clk_i = 1'b0;
    logic            rstn_i = 1'b0;
    logic            adc_rstn_i = 1'b0;
    logic [7:0]      addr_i = 8'h00;
    logic [31:0]     wdata_i = 32'h0;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic [31:0]     rdata_o;
    logic [3:0][7:0] lv = 32'h0;
    logic [3:0][7:0] smp;
    logic            irq_n_o;
    logic            irq_oe_o;
    logic            wire_n;
    int              n_fail = 0;
    int              cmp_count = 0;

    always #4 mclk_i = ~mclk_i;
    always #16 adc_clk_i = ~adc_clk_i;

    light_sensor_result_and_irq #(.INT_CYCLES(INT_CYC)) i_light_sensor_result_and_irq (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .adc_clk_i(adc_clk_i), .adc_rstn_i(adc_rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .red_sample_i(smp[0]), .green_sample_i(smp[1]), .blue_sample_i(smp[2]),
        .ir_sample_i(smp[3]), .irq_pin_n_i(wire_n), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o));

    light_sample_source i_light_sample_source (.adc_clk_i(adc_clk_i), .level_i(lv),
        .irq_oe_i(irq_oe_o), .sample_o(smp), .irq_wire_n_o(wire_n));

    // ====================================================
    // shared tasks
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge mclk_i);
    endtask : rd

    task automatic wait_new(input int n);
        logic [31:0] d;
        int          k;
        for (int j = 0; j < n; j++) begin
            k = 0;
            d = 32'h0;
            while (d[1] !== 1'b1) begin
                rd(light_sensor_pkg::OFS_STATUS, d);
                k++;
                if (k > 200) begin
                    n_fail++;
                    finish_test();
                end
            end
        end
    endtask : wait_new

    task automatic settle(input logic [31:0] levels);
        logic [31:0] d;
        lv <= levels;
        rd(light_sensor_pkg::OFS_STATUS, d);
        wait_new(2);
    endtask : settle

    task automatic chk_oe(input logic exp);
        @(posedge mclk_i);
        #1 chk({31'h0, irq_oe_o}, {31'h0, exp});
        @(posedge mclk_i);
    endtask : chk_oe

    task automatic clr();
        wr(light_sensor_pkg::OFS_IRQ_CFG, 32'h0);
        wr(light_sensor_pkg::OFS_STATUS, 32'h1);
    endtask : clr

    // ====================================================
    // scenarios
    task automatic t_reset_values();
        logic [7:0]  a [9];
        logic [31:0] e [9];
        logic [31:0] d;
        a = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40};
        e = '{32'h0, 32'h0, 32'h1, 32'hFFFFF, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0};
        for (int i = 0; i < 9; i++) begin
            rd(a[i], d);
            chk(d, e[i]);
        end
    endtask : t_reset_values

    task automatic t_capture();
        logic [31:0] d;
        wr(light_sensor_pkg::OFS_CTRL, 32'h1);
        settle(32'h04030201);
        for (int i = 0; i < 4; i++) begin
            rd(light_sensor_pkg::OFS_RED + 8'(4 * i), d);
            chk(d, 32'(INT_CYC * lv[i]));
        end
        wr(light_sensor_pkg::OFS_RED, 32'h12345);
        rd(light_sensor_pkg::OFS_RED, d);
        chk(d, 32'(INT_CYC * lv[0]));
    endtask : t_capture

    task automatic t_select();
        logic [31:0] d;
        logic [31:0] l;
        wr(light_sensor_pkg::OFS_THR_HI, 32'h10);
        for (int ch = 0; ch < 4; ch++) begin
            l = 32'h01010101;
            l[8*ch +: 8] = 8'h08;
            settle(l);
            wr(light_sensor_pkg::OFS_IRQ_CFG, 32'(ch << 2));
            wait_new(2);
            chk_oe(1'b0);
            wr(light_sensor_pkg::OFS_IRQ_CFG, 32'(ch << 2) | 32'h1);
            wait_new(1);
            chk_oe(1'b1);
            rd(light_sensor_pkg::OFS_STATUS, d);
            chk({30'h0, d[2], d[0]}, 32'h1);
            clr();
            chk_oe(1'b0);
        end
    endtask : t_select

    task automatic t_persist();
        settle(32'h01010101);
        wr(light_sensor_pkg::OFS_THR_HI, 32'hFFFFF);
        wr(light_sensor_pkg::OFS_THR_LO, 32'h10);
        wr(light_sensor_pkg::OFS_PERSIST, 32'h2);
        wr(light_sensor_pkg::OFS_IRQ_CFG, 32'h1);
        wait_new(1);
        chk_oe(1'b0);
        wr(light_sensor_pkg::OFS_THR_LO, 32'h0);
        wait_new(1);
        wr(light_sensor_pkg::OFS_THR_LO, 32'h10);
        wait_new(1);
        chk_oe(1'b0);
        wait_new(1);
        chk_oe(1'b1);
        wr(light_sensor_pkg::OFS_IRQ_CFG, 32'h0);
        wr(light_sensor_pkg::OFS_STATUS, 32'h0);
        wait_new(1);
        chk_oe(1'b1);
        clr();
        chk_oe(1'b0);
        wr(light_sensor_pkg::OFS_THR_LO, 32'h0);
    endtask : t_persist

    task automatic t_variance();
        wr(light_sensor_pkg::OFS_PERSIST, 32'h1);
        wr(light_sensor_pkg::OFS_IRQ_CFG, 32'h3);
        wait_new(2);
        chk_oe(1'b0);
        lv[0] <= 8'h08;
        wait_new(3);
        chk_oe(1'b1);
        clr();
        wr(light_sensor_pkg::OFS_VAR, 32'h3);
        wr(light_sensor_pkg::OFS_IRQ_CFG, 32'h3);
        lv[0] <= 8'h01;
        wait_new(3);
        chk_oe(1'b0);
    endtask : t_variance

    initial begin
        repeat (16) @(posedge mclk_i);
        @(posedge adc_clk_i);
        adc_rstn_i <= 1'b1;
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        t_reset_values();
        t_capture();
        t_select();
        t_persist();
        t_variance();
        finish_test();
    end
endmodule : test_light_sensor_result_and_irq
